//--- pkg/cbo_pkg.sv
package cbo_pkg;

   localparam int DATA_W     = 8;
   localparam int BIT_IDX_W  = 3;
   localparam int REG_ADDR_W = 4;

   // Software register offsets
   localparam logic [REG_ADDR_W-1:0] OFS_WORK     = 4'h0;
   localparam logic [REG_ADDR_W-1:0] OFS_FLAGS    = 4'h1;
   localparam logic [REG_ADDR_W-1:0] OFS_PORT_A   = 4'h2;
   localparam logic [REG_ADDR_W-1:0] OFS_PORT_DIR = 4'h3;
   localparam logic [REG_ADDR_W-1:0] OFS_PIN_IN   = 4'h4;
   localparam logic [REG_ADDR_W-1:0] OFS_MEM_PTR  = 4'h5;
   localparam logic [REG_ADDR_W-1:0] OFS_MEM_DATA = 4'h6;

   // Flag field positions inside the flags register
   localparam int FLG_Z  = 0;
   localparam int FLG_C  = 1;
   localparam int FLG_AC = 2;
   localparam int FLG_OV = 3;

   // Reset values and a byte constant of one
   localparam logic [DATA_W-1:0] RST_WORK   = 8'h00;
   localparam logic [DATA_W-1:0] RST_PORT_A = 8'h00;
   localparam logic [DATA_W-1:0] RST_DIR    = 8'h00;
   localparam logic [DATA_W-1:0] RST_ZERO   = 8'h00;
   localparam logic [DATA_W-1:0] ONE        = 8'h01;

   // I/O register select for port bit instructions
   localparam logic IO_SEL_LATCH = 1'b0;
   localparam logic IO_SEL_DIR   = 1'b1;

   typedef enum logic [3:0] {
      OP_NOP,
      OP_INV_WORK,
      OP_INV_MEM,
      OP_NEG_WORK,
      OP_NEG_MEM,
      OP_BIT_CLEAR_IO,
      OP_BIT_HIGH_IO,
      OP_BIT_CLEAR_MEM,
      OP_BIT_HIGH_MEM,
      OP_BIT_SWAP_C
   } cbo_op_e;

   typedef struct packed {
      logic ov;
      logic ac;
      logic c;
      logic z;
   } cbo_flags_s;

   typedef struct packed {
      logic                   valid;
      cbo_op_e                op;
      logic [BIT_IDX_W-1:0]   bit_idx;
      logic                   io_sel;
      logic [7:0]             mem_addr;
   } cbo_cmd_s;

   typedef struct packed {
      logic                   wr;
      logic                   rd;
      logic [REG_ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]      wdata;
   } cbo_bus_s;

endpackage

//--- rtl/cbo_core.sv
`timescale 1ns/1ps
`default_nettype none

module cbo_core
   import cbo_pkg::*;
#(
   parameter int MEM_DEPTH = 64
) (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // Instruction issue
   input  wire cbo_cmd_s               cmd,
   output logic                        cmd_done,
   // Software register port
   input  wire cbo_bus_s               bus,
   output logic [DATA_W-1:0]           rdata,
   // Core state views
   output logic [DATA_W-1:0]           working_register,
   output cbo_flags_s                  flags,
   // Port A pins
   input  wire logic [DATA_W-1:0]      pin_in,
   output logic [DATA_W-1:0]           pin_out,
   output logic [DATA_W-1:0]           pin_oe
);

   localparam int MEM_AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

   // Pointer range must match the array exactly so no address reads past its end
   if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || MEM_DEPTH != (1 << MEM_AW)) begin : g_bad_depth
      $error("MEM_DEPTH must be a power of two between 2 and 256");
   end

   typedef struct packed {
      logic [DATA_W-1:0]  work;
      cbo_flags_s         flg;
      logic [DATA_W-1:0]  port_a_latch;
      logic [DATA_W-1:0]  dir;
      logic [DATA_W-1:0]  pin_s1;
      logic [DATA_W-1:0]  pin_s2;
      logic [MEM_AW-1:0]  mem_ptr;
      logic [DATA_W-1:0]  rdata;
      logic               done;
   } cbo_state_s;

   cbo_state_s         st_r;
   cbo_state_s         st_nxt;
   logic [DATA_W-1:0]  mem [MEM_DEPTH];
   logic               mem_we;
   logic [MEM_AW-1:0]  mem_wa;
   logic [DATA_W-1:0]  mem_wd;

   // One-hot mask for a bit position
   function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_IDX_W-1:0] idx);
      bit_mask = ONE << idx;
   endfunction

   // Two's complement of a byte, wrapping modulo 256
   function automatic logic [DATA_W-1:0] twos(input logic [DATA_W-1:0] v);
      twos = DATA_W'(~v + ONE);
   endfunction

   logic [MEM_AW-1:0]  cmd_ma;
   logic [DATA_W-1:0]  mem_rd;
   logic [DATA_W-1:0]  mask;
   logic               cmd_bit_dir;
   logic               cmd_bit_pin;

   assign cmd_ma      = cmd.mem_addr[MEM_AW-1:0];
   assign mem_rd      = mem[cmd_ma];
   assign mask        = bit_mask(cmd.bit_idx);
   assign cmd_bit_dir = st_r.dir[cmd.bit_idx];
   assign cmd_bit_pin = st_r.pin_s2[cmd.bit_idx];

   always_comb begin
      logic [DATA_W-1:0] res;
      res    = RST_ZERO;
      st_nxt = st_r;
      mem_we = 1'b0;
      mem_wa = st_r.mem_ptr;
      mem_wd = bus.wdata;

      st_nxt.pin_s1 = pin_in;
      st_nxt.pin_s2 = st_r.pin_s1;
      st_nxt.done   = 1'b0;

      // Software register writes; an instruction in the same cycle overrides
      if (bus.wr) begin
         case (bus.addr)
            OFS_WORK:     st_nxt.work         = bus.wdata;
            OFS_FLAGS:    st_nxt.flg          = bus.wdata[FLG_OV:FLG_Z];
            OFS_PORT_A:   st_nxt.port_a_latch = bus.wdata;
            OFS_PORT_DIR: st_nxt.dir          = bus.wdata;
            OFS_MEM_PTR:  st_nxt.mem_ptr      = bus.wdata[MEM_AW-1:0];
            OFS_MEM_DATA: mem_we              = 1'b1;
            default: ;
         endcase
      end

      // Reads answer one cycle later; unmapped offsets read zero
      if (bus.rd) begin
         case (bus.addr)
            OFS_WORK:     st_nxt.rdata = st_r.work;
            OFS_FLAGS:    st_nxt.rdata = {4'h0, st_r.flg};
            OFS_PORT_A:   st_nxt.rdata = st_r.port_a_latch;
            OFS_PORT_DIR: st_nxt.rdata = st_r.dir;
            OFS_PIN_IN:   st_nxt.rdata = st_r.pin_s2;
            OFS_MEM_PTR:  st_nxt.rdata = DATA_W'(st_r.mem_ptr);
            OFS_MEM_DATA: st_nxt.rdata = mem[st_r.mem_ptr];
            default:      st_nxt.rdata = RST_ZERO;
         endcase
      end

      // Whole read-modify-write resolves in this cycle
      if (cmd.valid) begin
         st_nxt.done = (cmd.op != OP_NOP);
         case (cmd.op)
            OP_INV_WORK: begin
               res            = ~st_r.work;
               st_nxt.work    = res;
               st_nxt.flg.z   = (res == RST_ZERO);
            end
            OP_NEG_WORK: begin
               res            = twos(st_r.work);
               st_nxt.work    = res;
               st_nxt.flg.z   = (res == RST_ZERO);
            end
            OP_INV_MEM: begin
               res            = ~mem_rd;
               mem_we         = 1'b1;
               mem_wa         = cmd_ma;
               mem_wd         = res;
               st_nxt.flg.z   = (res == RST_ZERO);
            end
            OP_NEG_MEM: begin
               res            = twos(mem_rd);
               mem_we         = 1'b1;
               mem_wa         = cmd_ma;
               mem_wd         = res;
               st_nxt.flg.z   = (res == RST_ZERO);
            end
            OP_BIT_CLEAR_IO: begin
               if (cmd.io_sel == IO_SEL_DIR) begin
                  st_nxt.dir = st_r.dir & ~mask;
               end else begin
                  st_nxt.port_a_latch = st_r.port_a_latch & ~mask;
               end
            end
            OP_BIT_HIGH_IO: begin
               if (cmd.io_sel == IO_SEL_DIR) begin
                  st_nxt.dir = st_r.dir | mask;
               end else begin
                  st_nxt.port_a_latch = st_r.port_a_latch | mask;
               end
            end
            OP_BIT_CLEAR_MEM: begin
               mem_we = 1'b1;
               mem_wa = cmd_ma;
               mem_wd = mem_rd & ~mask;
            end
            OP_BIT_HIGH_MEM: begin
               mem_we = 1'b1;
               mem_wa = cmd_ma;
               mem_wd = mem_rd | mask;
            end
            OP_BIT_SWAP_C: begin
               if (cmd.io_sel == IO_SEL_DIR) begin
                  st_nxt.flg.c = cmd_bit_dir;
                  st_nxt.dir[cmd.bit_idx] = st_r.flg.c;
               end else if (cmd_bit_dir) begin
                  st_nxt.flg.c = st_r.port_a_latch[cmd.bit_idx];
                  st_nxt.port_a_latch[cmd.bit_idx] = st_r.flg.c;
               end else begin
                  st_nxt.flg.c = cmd_bit_pin;
                  st_nxt.port_a_latch[cmd.bit_idx] = st_r.flg.c;
               end
            end
            default: st_nxt.done = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= '{work: RST_WORK, flg: '0, port_a_latch: RST_PORT_A, dir: RST_DIR,
                   pin_s1: RST_ZERO, pin_s2: RST_ZERO, mem_ptr: '0,
                   rdata: RST_ZERO, done: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign cmd_done         = st_r.done;
   assign rdata            = st_r.rdata;
   assign working_register = st_r.work;
   assign flags            = st_r.flg;
   assign pin_out          = st_r.port_a_latch;
   assign pin_oe           = st_r.dir;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_inv_work;
      cmd.valid && cmd.op == OP_INV_WORK
      |=> working_register == ~$past(working_register) && flags.z == (working_register == 8'h00);
   endproperty
   a_inv_work: assert property (p_inv_work) else $error("invert work result wrong");

   property p_inv_mem;
      cmd.valid && cmd.op == OP_INV_MEM
      |=> mem[$past(cmd_ma)] == ~$past(mem_rd) && flags.c == $past(flags.c);
   endproperty
   a_inv_mem: assert property (p_inv_mem) else $error("invert memory result wrong");

   property p_neg_work;
      cmd.valid && cmd.op == OP_NEG_WORK
      |=> working_register == 8'(~$past(working_register) + 8'h01)
          && flags.ov == $past(flags.ov) && flags.ac == $past(flags.ac);
   endproperty
   a_neg_work: assert property (p_neg_work) else $error("negate work result wrong");

   property p_neg_mem;
      cmd.valid && cmd.op == OP_NEG_MEM
      |=> mem[$past(cmd_ma)] == 8'(8'h00 - $past(mem_rd)) && flags.z == (mem[$past(cmd_ma)] == 8'h00);
   endproperty
   a_neg_mem: assert property (p_neg_mem) else $error("negate memory result wrong");

   property p_clr_io;
      cmd.valid && cmd.op == OP_BIT_CLEAR_IO && cmd.io_sel == IO_SEL_LATCH
      |=> pin_out == ($past(pin_out) & ~$past(mask)) && flags == $past(flags);
   endproperty
   a_clr_io: assert property (p_clr_io) else $error("port bit clear wrong");

   property p_set_io;
      cmd.valid && cmd.op == OP_BIT_HIGH_IO && cmd.io_sel == IO_SEL_LATCH
      |=> pin_out == ($past(pin_out) | $past(mask)) && flags == $past(flags);
   endproperty
   a_set_io: assert property (p_set_io) else $error("port bit set wrong");

   property p_clr_mem;
      cmd.valid && cmd.op == OP_BIT_CLEAR_MEM
      |=> mem[$past(cmd_ma)] == ($past(mem_rd) & ~$past(mask)) && flags == $past(flags);
   endproperty
   a_clr_mem: assert property (p_clr_mem) else $error("memory bit clear wrong");

   property p_set_mem;
      cmd.valid && cmd.op == OP_BIT_HIGH_MEM
      |=> mem[$past(cmd_ma)] == ($past(mem_rd) | $past(mask)) && flags == $past(flags);
   endproperty
   a_set_mem: assert property (p_set_mem) else $error("memory bit set wrong");

   property p_swap_out;
      cmd.valid && cmd.op == OP_BIT_SWAP_C && cmd.io_sel == IO_SEL_LATCH && cmd_bit_dir
      |=> pin_out[$past(cmd.bit_idx)] == $past(flags.c)
          && flags.c == $past(pin_out[cmd.bit_idx]) && flags.z == $past(flags.z);
   endproperty
   a_swap_out: assert property (p_swap_out) else $error("swap to output wrong");

   property p_swap_in;
      cmd.valid && cmd.op == OP_BIT_SWAP_C && cmd.io_sel == IO_SEL_LATCH && !cmd_bit_dir
      |=> flags.c == $past(cmd_bit_pin) && flags.ov == $past(flags.ov);
   endproperty
   a_swap_in: assert property (p_swap_in) else $error("swap from input wrong");

   // A second pulse is allowed only when the next cycle issued again
   property p_done;
      cmd.valid && cmd.op != OP_NOP && cmd.op <= OP_BIT_SWAP_C
      |=> cmd_done ##1 (!cmd_done || $past(cmd.valid && cmd.op != OP_NOP));
   endproperty
   a_done: assert property (p_done) else $error("done pulse wrong");

   property p_inv_keep;
      cmd.valid && cmd.op == OP_INV_WORK
      |=> flags.c == $past(flags.c) && flags.ac == $past(flags.ac)
          && flags.ov == $past(flags.ov);
   endproperty
   a_inv_keep: assert property (p_inv_keep) else $error("invert work touched a flag");

   property p_neg_keep;
      cmd.valid && cmd.op == OP_NEG_WORK
      |=> flags.z == (working_register == 8'h00) && flags.c == $past(flags.c);
   endproperty
   a_neg_keep: assert property (p_neg_keep) else $error("negate work flags wrong");

   property p_invm_keep;
      cmd.valid && cmd.op == OP_INV_MEM
      |=> flags.z == (mem[$past(cmd_ma)] == 8'h00) && flags.ac == $past(flags.ac)
          && flags.ov == $past(flags.ov);
   endproperty
   a_invm_keep: assert property (p_invm_keep) else $error("memory invert flags");

   property p_negm_keep;
      cmd.valid && cmd.op == OP_NEG_MEM
      |=> flags.c == $past(flags.c) && flags.ac == $past(flags.ac)
          && flags.ov == $past(flags.ov);
   endproperty
   a_negm_keep: assert property (p_negm_keep) else $error("memory negate flags");

   property p_swap_dir;
      cmd.valid && cmd.op == OP_BIT_SWAP_C && cmd.io_sel == IO_SEL_DIR
      |=> pin_oe[$past(cmd.bit_idx)] == $past(flags.c)
          && flags.c == $past(pin_oe[cmd.bit_idx]);
   endproperty
   a_swap_dir: assert property (p_swap_dir) else $error("direction swap wrong");

   property p_swap_keep;
      cmd.valid && cmd.op == OP_BIT_SWAP_C
      |=> flags.z == $past(flags.z) && flags.ac == $past(flags.ac)
          && flags.ov == $past(flags.ov);
   endproperty
   a_swap_keep: assert property (p_swap_keep) else $error("swap touched a flag");

   // Refused no-op leaves working_register, flags and pin_out alone and gives no pulse
   property p_nop;
      cmd.valid && cmd.op == OP_NOP && !bus.wr
      |=> !cmd_done && working_register == $past(working_register)
          && flags == $past(flags) && pin_out == $past(pin_out);
   endproperty
   a_nop: assert property (p_nop) else $error("no-op changed state");

   c_neg_zero: cover property (cmd.valid && cmd.op == OP_NEG_WORK ##1 flags.z);
   c_swap_out: cover property (cmd.valid && cmd.op == OP_BIT_SWAP_C && cmd_bit_dir);
   c_swap_in:  cover property (cmd.valid && cmd.op == OP_BIT_SWAP_C && !cmd_bit_dir);
   c_mem_rmw:  cover property (cmd.valid && cmd.op == OP_INV_MEM ##1 cmd.valid && cmd.op == OP_INV_MEM);
   c_swap_dir: cover property (cmd.valid && cmd.op == OP_BIT_SWAP_C && cmd.io_sel == IO_SEL_DIR);

endmodule

`default_nettype wire

//--- tb/tb_complement_and_bit_ops.sv
`timescale 1ns/1ps
`default_nettype none

module tb_complement_and_bit_ops;
   import cbo_pkg::*;

   logic              mclk;
   logic              rst;
   cbo_cmd_s          cmd;
   logic              cmd_done;
   cbo_bus_s          bus;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] working_register;
   cbo_flags_s        flags;
   logic [DATA_W-1:0] pin_in;
   logic [DATA_W-1:0] pin_out;
   logic [DATA_W-1:0] pin_oe;
   int                num_errors;
   int                checks_done;
   logic [DATA_W-1:0] rd_v;

   cbo_core #(.MEM_DEPTH(64)) dut (
      .mclk             (mclk),
      .rst              (rst),
      .cmd              (cmd),
      .cmd_done         (cmd_done),
      .bus              (bus),
      .rdata            (rdata),
      .working_register (working_register),
      .flags            (flags),
      .pin_in           (pin_in),
      .pin_out          (pin_out),
      .pin_oe           (pin_oe)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus_wr(input logic [REG_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk);
      bus <= {1'b1, 1'b0, a, d};
      @(posedge mclk);
      bus <= '0;
   endtask

   // Read data appear in the cycle after the strobe and hold until the next read
   task automatic bus_rd(input logic [REG_ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge mclk);
      bus <= {1'b0, 1'b1, a, 8'h00};
      @(posedge mclk);
      bus <= '0;
      #1;
      d = rdata;
   endtask

   task automatic issue(input cbo_op_e op, input logic [2:0] b, input logic io,
                        input logic [7:0] ma);
      @(posedge mclk);
      cmd <= {1'b1, op, b, io, ma};
      @(posedge mclk);
      cmd <= '0;
      #1;
      check("cmd_done", {7'h00, cmd_done}, 8'h01);
   endtask

   task automatic work_op(input cbo_op_e op, input logic [7:0] init, input logic [7:0] exp);
      bus_wr(OFS_WORK, init);
      issue(op, 3'h0, IO_SEL_LATCH, 8'h00);
      check("work", working_register, exp);
      check("flags", {4'h0, flags}, {4'h0, 3'b111, exp == 8'h00});
   endtask

   task automatic mem_op(input logic [7:0] ma, input logic [7:0] init, input cbo_op_e op,
                         input logic [2:0] b, input logic [7:0] exp, input logic [7:0] fexp);
      bus_wr(OFS_MEM_PTR, ma);
      bus_wr(OFS_MEM_DATA, init);
      issue(op, b, IO_SEL_LATCH, ma);
      bus_rd(OFS_MEM_DATA, rd_v);
      check("mem", rd_v, exp);
      check("flags", {4'h0, flags}, fexp);
   endtask

   task automatic io_op(input logic io, input logic [7:0] init, input cbo_op_e op,
                        input logic [2:0] b, input logic [7:0] exp);
      bus_wr(io ? OFS_PORT_DIR : OFS_PORT_A, init);
      issue(op, b, io, 8'h00);
      check("io", io ? pin_oe : pin_out, exp);
      check("flags", {4'h0, flags}, 8'h0F);
   endtask

   initial begin
      repeat (2000) @(posedge mclk);
      num_errors++;
      report_and_stop();
   end

   initial begin
      num_errors = 0;
      checks_done = 0;
      rst = 1'b1;
      cmd = '0;
      bus = '0;
      pin_in = 8'h00;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      #1;
      check("work_rst", working_register, RST_WORK);
      check("flags_rst", {4'h0, flags}, RST_ZERO);
      check("oe_rst", pin_oe, RST_DIR);
      check("out_rst", pin_out, RST_PORT_A);
      bus_rd(4'hF, rd_v);
      check("unmapped", rd_v, 8'h00);
      // Carry, half carry and overflow held high to catch stray updates
      bus_wr(OFS_FLAGS, 8'h0E);
      work_op(OP_INV_WORK, 8'hFF, 8'h00);
      work_op(OP_INV_WORK, 8'h38, 8'hC7);
      work_op(OP_NEG_WORK, 8'h38, 8'hC8);
      work_op(OP_NEG_WORK, 8'h00, 8'h00);
      mem_op(8'h05, 8'h38, OP_INV_MEM, 3'h0, 8'hC7, 8'h0E);
      mem_op(8'h3F, 8'hFF, OP_INV_MEM, 3'h0, 8'h00, 8'h0F);
      mem_op(8'h3F, 8'hC7, OP_NEG_MEM, 3'h0, 8'h39, 8'h0E);
      mem_op(8'h05, 8'h00, OP_NEG_MEM, 3'h0, 8'h00, 8'h0F);
      mem_op(8'h05, 8'hA5, OP_BIT_CLEAR_MEM, 3'h0, 8'hA4, 8'h0F);
      mem_op(8'h3F, 8'hFF, OP_BIT_CLEAR_MEM, 3'h7, 8'h7F, 8'h0F);
      mem_op(8'h05, 8'h00, OP_BIT_HIGH_MEM, 3'h7, 8'h80, 8'h0F);
      mem_op(8'h3F, 8'h5A, OP_BIT_HIGH_MEM, 3'h0, 8'h5B, 8'h0F);
      io_op(IO_SEL_LATCH, 8'h5A, OP_BIT_CLEAR_IO, 3'h1, 8'h58);
      io_op(IO_SEL_LATCH, 8'h5A, OP_BIT_HIGH_IO, 3'h7, 8'hDA);
      io_op(IO_SEL_DIR, 8'h00, OP_BIT_HIGH_IO, 3'h0, 8'h01);
      io_op(IO_SEL_DIR, 8'hFF, OP_BIT_CLEAR_IO, 3'h3, 8'hF7);
      // Bit 0 is an output, bit 3 an input from here on
      bus_wr(OFS_PORT_A, 8'h00);
      bus_wr(OFS_FLAGS, 8'h0E);
      issue(OP_BIT_SWAP_C, 3'h0, IO_SEL_LATCH, 8'h00);
      check("pin_out", pin_out, 8'h01);
      check("flags", {4'h0, flags}, 8'h0C);
      issue(OP_BIT_SWAP_C, 3'h0, IO_SEL_LATCH, 8'h00);
      check("pin_out", pin_out, 8'h00);
      check("flags", {4'h0, flags}, 8'h0E);
      @(posedge mclk);
      pin_in <= 8'h08;
      repeat (3) @(posedge mclk);
      bus_rd(OFS_PIN_IN, rd_v);
      check("pin_in", rd_v, 8'h08);
      bus_wr(OFS_FLAGS, 8'h0C);
      issue(OP_BIT_SWAP_C, 3'h3, IO_SEL_LATCH, 8'h00);
      check("flags", {4'h0, flags}, 8'h0E);
      check("oe", pin_oe, 8'hF7);
      @(posedge mclk);
      pin_in <= 8'h00;
      repeat (3) @(posedge mclk);
      issue(OP_BIT_SWAP_C, 3'h3, IO_SEL_LATCH, 8'h00);
      check("flags", {4'h0, flags}, 8'h0C);
      // Back-to-back issue: the second sees the first's result
      bus_wr(OFS_WORK, 8'h38);
      @(posedge mclk);
      cmd <= {1'b1, OP_NEG_WORK, 3'h0, IO_SEL_LATCH, 8'h00};
      @(posedge mclk);
      cmd <= {1'b1, OP_INV_WORK, 3'h0, IO_SEL_LATCH, 8'h00};
      @(posedge mclk);
      cmd <= '0;
      #1;
      check("work", working_register, 8'h37);
      check("cmd_done", {7'h00, cmd_done}, 8'h01);
      check("flags", {4'h0, flags}, 8'h0C);
      // A no-op is refused: no done pulse and nothing moves
      @(posedge mclk);
      cmd <= {1'b1, OP_NOP, 3'h0, IO_SEL_LATCH, 8'h00};
      @(posedge mclk);
      cmd <= '0;
      #1;
      check("nop_done", {7'h00, cmd_done}, 8'h00);
      check("nop_work", working_register, 8'h37);
      check("nop_flags", {4'h0, flags}, 8'h0C);
      // Exchange with the direction bit: output bit 0 turns input
      issue(OP_BIT_SWAP_C, 3'h0, IO_SEL_DIR, 8'h00);
      check("oe", pin_oe, 8'hF6);
      check("flags", {4'h0, flags}, 8'h0E);
      // Read back the work, flags, direction, latch and pointer registers
      bus_rd(OFS_WORK, rd_v);
      check("rd_work", rd_v, 8'h37);
      bus_rd(OFS_FLAGS, rd_v);
      check("rd_flags", rd_v, 8'h0E);
      bus_rd(OFS_PORT_DIR, rd_v);
      check("rd_dir", rd_v, 8'hF6);
      bus_rd(OFS_PORT_A, rd_v);
      check("rd_latch", rd_v, 8'h08);
      bus_rd(OFS_MEM_PTR, rd_v);
      check("rd_ptr", rd_v, 8'h3F);
      // Mid-run reset returns every view to its reset value
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      #1;
      check("work_rst2", working_register, RST_WORK);
      check("flags_rst2", {4'h0, flags}, RST_ZERO);
      check("oe_rst2", pin_oe, RST_DIR);
      check("out_rst2", pin_out, RST_PORT_A);
      check("rdata_rst2", rdata, RST_ZERO);
      check("done_rst2", {7'h00, cmd_done}, 8'h00);
      report_and_stop();
   end

endmodule

`default_nettype wire
